// ===== acev_cfg.svh
// Register offsets, field positions, reset values and encodings for the comparator event control.
// Assumes inclusion by the package and the design files, byte-addressed APB with 32-bit data.
`ifndef ACEV_CFG_SVH
`define ACEV_CFG_SVH

`define ACEV_OFS_REFCLK 12'h0AF
`define ACEV_ADDR_REFCLK 12'h2BC
`define ACEV_ADDR_BCTRL 12'h300
`define ACEV_ADDR_STAT 12'h304
`define ACEV_ADDR_CLR 12'h308
`define ACEV_ADDR_IEN 12'h30C
`define ACEV_RST_REFCLK 8'h00
`define ACEV_RST_BCTRL 8'hC0
`define ACEV_BIT_CMP_B_INPUT_CONNECT 5
`define ACEV_BIT_CFB 4
`define ACEV_BIT_CMP_B_ENABLE 3
`define ACEV_MODE_LSB 0
`define ACEV_CBC_LSB 6
`define ACEV_RFB_LSB 4
`define ACEV_CAC_LSB 2
`define ACEV_RFA_LSB 0
`define ACEV_CLK_SYS 2'h0
`define ACEV_CLK_T0 2'h1
`define ACEV_CLK_T1 2'h2
`define ACEV_CLK_T2 2'h3
`define ACEV_DEB_SAMPLES 2
`define ACEV_EVT_FLAG 0
`define ACEV_EVT_EDGE 1
`define ACEV_NUM_EVT 2

`endif

// ===== acev_pkg.sv
// Types shared by the comparator event control files.
// Assumes the constants header is present in the include path.
`include "acev_cfg.svh"
package acev_pkg;

   typedef enum logic [2:0] {
      ACEV_LOW_LEVEL,
      ACEV_RISE,
      ACEV_DEB_TOGGLE,
      ACEV_DEB_RISE,
      ACEV_FALL,
      ACEV_TOGGLE,
      ACEV_DEB_FALL,
      ACEV_HIGH_LEVEL
   } acev_mode_t;

   typedef struct packed {
      logic [1:0] b_clock_sel;
      logic [1:0] b_neg_sel;
      logic [1:0] a_clock_sel;
      logic [1:0] a_neg_sel;
   } acev_refclk_t;

   typedef struct packed {
      logic [1:0] pos_sel;
      logic input_connect;
      logic irq_flag;
      logic enable;
      logic [2:0] irq_mode;
   } acev_bctrl_t;

endpackage

// ===== acev_sampler.sv
// Samples one comparator output on a selected tick and qualifies changes over repeat samples.
// Assumes timer overflow inputs are one-cycle pulses synchronous to the clock.
`timescale 1ns/1ps
module acev_sampler
   import acev_pkg::*;
#(
   parameter int DEB_SAMPLES = `ACEV_DEB_SAMPLES
) (
   // Clock and reset.
   input wire logic sys_clk_in,
   input wire logic reset_n_in,
   // Tick selection.
   input wire logic [1:0] clock_sel_in,
   input wire logic [2:0] tmr_ovf_in,
   input wire logic debounce_in,
   // Comparator level.
   input wire logic cmp_raw_in,
   output logic level_out,
   output logic sample_tick_out
);

   logic tick;
   logic sample_ff;
   logic [3:0] stable_cnt_ff;
   logic [3:0] nxt_stable_cnt;
   logic nxt_level;

   assign tick = (clock_sel_in == `ACEV_CLK_SYS) ? 1'b1 :
                 (clock_sel_in == `ACEV_CLK_T0) ? tmr_ovf_in[0] :
                 (clock_sel_in == `ACEV_CLK_T1) ? tmr_ovf_in[1] : tmr_ovf_in[2];

   // A changed sample must repeat before the qualified level follows it in debounced modes.
   assign nxt_stable_cnt = (sample_ff == level_out) ? 4'h0 :
                           (tick ? stable_cnt_ff + 4'h1 : stable_cnt_ff);
   assign nxt_level = !debounce_in ? sample_ff :
                      (tick && sample_ff != level_out &&
                       stable_cnt_ff >= 4'(DEB_SAMPLES - 1)) ? sample_ff : level_out;

   always_ff @(posedge sys_clk_in) begin
      if (!reset_n_in) begin
         sample_ff <= 1'b0;
         stable_cnt_ff <= 4'h0;
         level_out <= 1'b0;
         sample_tick_out <= 1'b0;
      end else begin
         if (tick) begin
            sample_ff <= cmp_raw_in;
         end
         stable_cnt_ff <= nxt_stable_cnt;
         level_out <= nxt_level;
         sample_tick_out <= tick;
      end
   end

endmodule

// ===== acev_ctrl.sv
// Comparator event control: reference and clock selection, comparator B enable, modes and flag.
// Assumes an APB master on the register side and an analog comparator core beside it.
`timescale 1ns/1ps
module acev_ctrl
   import acev_pkg::*;
#(
   parameter int DEB_SAMPLES = `ACEV_DEB_SAMPLES
) (
   // Clock and reset.
   input wire logic sys_clk_in,
   input wire logic reset_n_in,
   // APB slave.
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [11:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   // Comparators and timers.
   input wire logic cmp_b_raw_in,
   input wire logic cmp_a_raw_in,
   input wire logic [2:0] tmr_ovf_in,
   // Analog routing and pin control.
   output logic cmp_b_out,
   output logic cmp_a_out,
   output logic [1:0] cmp_b_pos_input_sel_out,
   output logic [1:0] cmp_b_neg_input_sel_out,
   output logic [1:0] cmp_a_neg_input_sel_out,
   output logic cmp_b_input_connect_out,
   output logic pins_input_only_out,
   output logic cmp_b_irq_flag_out,
   output logic irq_out
);

   ////////////////////////////////////////////////////////////////////////////////
   // Register state.

   acev_refclk_t refclk_ff;
   acev_bctrl_t bctrl_ff;
   logic [`ACEV_NUM_EVT-1:0] stat_ff;
   logic [`ACEV_NUM_EVT-1:0] ien_ff;
   logic lvl_prev_ff;
   logic [31:0] nxt_prdata;
   logic nxt_flag;
   logic [`ACEV_NUM_EVT-1:0] nxt_stat;

   ////////////////////////////////////////////////////////////////////////////////
   // Bus decode.

   function automatic logic hit(input logic [11:0] a, input logic [11:0] ref_addr);
      hit = (a == ref_addr);
   endfunction

   wire access = psel_in && penable_in;
   wire wr = access && pwrite_in;
   wire wr_ref = wr && hit(paddr_in, `ACEV_ADDR_REFCLK);
   wire wr_bctrl = wr && hit(paddr_in, `ACEV_ADDR_BCTRL);
   wire wr_clr = wr && hit(paddr_in, `ACEV_ADDR_CLR);
   wire wr_ien = wr && hit(paddr_in, `ACEV_ADDR_IEN);
   wire mapped = hit(paddr_in, `ACEV_ADDR_REFCLK) || hit(paddr_in, `ACEV_ADDR_BCTRL) ||
                 hit(paddr_in, `ACEV_ADDR_STAT) || hit(paddr_in, `ACEV_ADDR_CLR) ||
                 hit(paddr_in, `ACEV_ADDR_IEN);

   ////////////////////////////////////////////////////////////////////////////////
   // Comparator A and B sampling and comparator B event detection.

   acev_mode_t mode;
   logic b_level;
   logic b_tick;
   logic debounced;
   logic [1:0] b_sel_eff;
   logic cond;
   logic edge_evt;

   assign mode = acev_mode_t'(bctrl_ff.irq_mode);
   assign debounced = (mode == ACEV_DEB_TOGGLE) || (mode == ACEV_DEB_RISE) ||
                      (mode == ACEV_DEB_FALL);
   // Debounce delays always come from Timer 1, whatever the clock field holds.
   assign b_sel_eff = debounced ? `ACEV_CLK_T1 : refclk_ff.b_clock_sel;

   acev_sampler #(.DEB_SAMPLES(DEB_SAMPLES)) u_samp_b (
      .sys_clk_in(sys_clk_in),
      .reset_n_in(reset_n_in),
      .clock_sel_in(b_sel_eff),
      .tmr_ovf_in(tmr_ovf_in),
      .debounce_in(debounced),
      .cmp_raw_in(cmp_b_raw_in),
      .level_out(b_level),
      .sample_tick_out(b_tick)
   );

   logic a_level;
   acev_sampler #(.DEB_SAMPLES(DEB_SAMPLES)) u_samp_a (
      .sys_clk_in(sys_clk_in),
      .reset_n_in(reset_n_in),
      .clock_sel_in(refclk_ff.a_clock_sel),
      .tmr_ovf_in(tmr_ovf_in),
      .debounce_in(1'b0),
      .cmp_raw_in(cmp_a_raw_in),
      .level_out(a_level),
      .sample_tick_out()
   );

   wire b_gated = b_level && bctrl_ff.enable;
   wire rise = b_gated && !lvl_prev_ff;
   wire fall = !b_gated && lvl_prev_ff;

   always_comb begin
      case (mode)
         ACEV_LOW_LEVEL: cond = !b_gated;
         ACEV_RISE: cond = rise;
         ACEV_DEB_TOGGLE: cond = rise || fall;
         ACEV_DEB_RISE: cond = rise;
         ACEV_FALL: cond = fall;
         ACEV_TOGGLE: cond = rise || fall;
         ACEV_DEB_FALL: cond = fall;
         ACEV_HIGH_LEVEL: cond = b_gated;
         default: cond = 1'b0;
      endcase
   end

   assign edge_evt = bctrl_ff.enable && (rise || fall);
   // Set wins over a software clear in the same cycle.
   assign nxt_flag = (cond && bctrl_ff.enable) ? 1'b1 :
                     (wr_bctrl && !pwdata_in[`ACEV_BIT_CFB]) ? 1'b0 : bctrl_ff.irq_flag;
   assign nxt_stat = ({edge_evt, cond && bctrl_ff.enable}) |
                     (stat_ff & ~(wr_clr ? pwdata_in[`ACEV_NUM_EVT-1:0] : 2'h0));

   ////////////////////////////////////////////////////////////////////////////////
   // Read data.

   assign nxt_prdata = hit(paddr_in, `ACEV_ADDR_REFCLK) ? {24'h000000, refclk_ff} :
                       hit(paddr_in, `ACEV_ADDR_BCTRL) ? {24'h000000, bctrl_ff} :
                       hit(paddr_in, `ACEV_ADDR_STAT) ? {30'h00000000, stat_ff} :
                       hit(paddr_in, `ACEV_ADDR_IEN) ? {30'h00000000, ien_ff} : 32'h00000000;

   ////////////////////////////////////////////////////////////////////////////////
   // Registers.

   always_ff @(posedge sys_clk_in) begin
      if (!reset_n_in) begin
         refclk_ff <= acev_refclk_t'(`ACEV_RST_REFCLK);
         bctrl_ff <= acev_bctrl_t'(`ACEV_RST_BCTRL);
         stat_ff <= 2'h0;
         ien_ff <= 2'h0;
         lvl_prev_ff <= 1'b0;
      end else begin
         if (wr_ref) begin
            refclk_ff <= acev_refclk_t'(pwdata_in[7:0]);
         end
         if (wr_bctrl) begin
            bctrl_ff.pos_sel <= pwdata_in[7:6];
            bctrl_ff.input_connect <= pwdata_in[`ACEV_BIT_CMP_B_INPUT_CONNECT];
            bctrl_ff.enable <= pwdata_in[`ACEV_BIT_CMP_B_ENABLE];
            bctrl_ff.irq_mode <= pwdata_in[2:0];
         end
         bctrl_ff.irq_flag <= nxt_flag;
         if (wr_ien) begin
            ien_ff <= pwdata_in[`ACEV_NUM_EVT-1:0];
         end
         stat_ff <= nxt_stat;
         lvl_prev_ff <= b_gated;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Output flip-flops.

   always_ff @(posedge sys_clk_in) begin
      if (!reset_n_in) begin
         prdata_out <= 32'h00000000;
         pready_out <= 1'b0;
         pslverr_out <= 1'b0;
         cmp_b_out <= 1'b0;
         cmp_a_out <= 1'b0;
         cmp_b_pos_input_sel_out <= 2'h0;
         cmp_b_neg_input_sel_out <= 2'h0;
         cmp_a_neg_input_sel_out <= 2'h0;
         cmp_b_input_connect_out <= 1'b0;
         pins_input_only_out <= 1'b0;
         cmp_b_irq_flag_out <= 1'b0;
         irq_out <= 1'b0;
      end else begin
         pready_out <= psel_in && !penable_in;
         pslverr_out <= psel_in && !penable_in && !mapped;
         prdata_out <= nxt_prdata;
         cmp_b_out <= b_gated;
         cmp_a_out <= a_level;
         cmp_b_pos_input_sel_out <= bctrl_ff.pos_sel;
         cmp_b_neg_input_sel_out <= refclk_ff.b_neg_sel;
         cmp_a_neg_input_sel_out <= refclk_ff.a_neg_sel;
         cmp_b_input_connect_out <= bctrl_ff.input_connect;
         pins_input_only_out <= bctrl_ff.enable;
         cmp_b_irq_flag_out <= bctrl_ff.irq_flag;
         irq_out <= |(stat_ff & ien_ff);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Checks.

   a_disabled_low: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
      !bctrl_ff.enable |=> !cmp_b_out) else $error("output high while disabled");
   a_no_flag_dis: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
      (!bctrl_ff.enable && !bctrl_ff.irq_flag) |=> !bctrl_ff.irq_flag)
      else $error("flag set while disabled");
   a_input_only: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
      ##1 pins_input_only_out == $past(bctrl_ff.enable))
      else $error("input-only not following enable");
   a_high_level: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
      (mode == ACEV_HIGH_LEVEL && b_gated) |=> bctrl_ff.irq_flag)
      else $error("high level not flagged");
   a_rise_flag: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
      (mode == ACEV_RISE && bctrl_ff.enable && b_gated && !lvl_prev_ff) |=> bctrl_ff.irq_flag)
      else $error("rise not flagged");
   a_deb_timer1: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
      debounced |-> b_sel_eff == `ACEV_CLK_T1) else $error("debounce not on timer 1");
   a_flag_sticky: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
      (bctrl_ff.irq_flag && !wr_bctrl) |=> bctrl_ff.irq_flag)
      else $error("flag cleared without write");
   a_ref_route: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
      wr_ref |=> ##1 cmp_b_neg_input_sel_out == $past(pwdata_in[5:4], 2))
      else $error("negative select not routed");
   a_connect: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
      wr_bctrl |=> ##1 cmp_b_input_connect_out == $past(pwdata_in[5], 2))
      else $error("connect not routed");

endmodule

// ===== acev_ctrl_bench.sv
// Self-checking bench for the comparator event control, driven over APB.
// Assumes the package and constants header are compiled first; timers are pulses that tmr_run can stop.
`timescale 1ns/1ps
`include "acev_cfg.svh"
module acev_ctrl_bench
   import acev_pkg::*;
;
   logic sys_clk_in = 1'b0;
   logic reset_n_in = 1'b0;
   logic psel_in = 1'b0;
   logic penable_in = 1'b0;
   logic pwrite_in = 1'b0;
   logic [11:0] paddr_in = 12'h000;
   logic [31:0] pwdata_in = 32'h00000000;
   logic [31:0] prdata_out;
   logic pready_out, pslverr_out, cmp_b_out, cmp_a_out, cmp_b_input_connect_out;
   logic pins_input_only_out, cmp_b_irq_flag_out, irq_out;
   logic [1:0] b_pos, b_neg, a_neg;
   logic cmp_b_raw_in = 1'b0;
   logic cmp_a_raw_in = 1'b0;
   logic [2:0] tmr_ovf_in = 3'h0;
   logic [2:0] tcnt = 3'h0;
   logic tmr_run = 1'b1;
   int err_total = 0;
   int comparisons = 0;
   int cycles = 0;
   logic [7:0] rise_set = 8'hAE;
   logic [7:0] fall_set = 8'h75;

   acev_ctrl DUT (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .psel_in(psel_in),
      .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
      .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
      .pslverr_out(pslverr_out), .cmp_b_raw_in(cmp_b_raw_in), .cmp_a_raw_in(cmp_a_raw_in),
      .tmr_ovf_in(tmr_ovf_in), .cmp_b_out(cmp_b_out), .cmp_a_out(cmp_a_out),
      .cmp_b_pos_input_sel_out(b_pos), .cmp_b_neg_input_sel_out(b_neg),
      .cmp_a_neg_input_sel_out(a_neg), .cmp_b_input_connect_out(cmp_b_input_connect_out),
      .pins_input_only_out(pins_input_only_out), .cmp_b_irq_flag_out(cmp_b_irq_flag_out),
      .irq_out(irq_out));

   initial begin
      forever #4 sys_clk_in = ~sys_clk_in;
   end

   // Timer overflows pulse at different phases so each clock source is distinct.
   always @(posedge sys_clk_in) begin
      tcnt <= tcnt + 3'h1;
      tmr_ovf_in <= tmr_run ? {tcnt == 3'h5, tcnt == 3'h3, tcnt[1:0] == 2'h0} : 3'h0;
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         err_total++;
         test_done();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic se);
      @(posedge sys_clk_in);
      psel_in <= 1'b1;
      penable_in <= 1'b0;
      pwrite_in <= wr;
      paddr_in <= a;
      pwdata_in <= wd;
      @(posedge sys_clk_in);
      penable_in <= 1'b1;
      do @(posedge sys_clk_in); while (pready_out !== 1'b1);
      rd = prdata_out;
      se = pslverr_out;
      psel_in <= 1'b0;
      penable_in <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
      // Registered outputs follow a write two edges after it is taken.
      idle(2);
   endtask

   task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input logic exp_err);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h00000000, r, e);
      chk("read data", exp, r);
      chk("slave error", {31'h0, exp_err}, {31'h0, e});
   endtask

   function automatic logic [31:0] bv(input logic en, input logic [2:0] md);
      acev_bctrl_t b;
      // The positive select stays put because every write here carries pos_sel 2; the connect bit is set as well.
      b = '{pos_sel: 2'h2, input_connect: 1'b1, irq_flag: 1'b0, enable: en, irq_mode: md};
      return {24'h000000, b};
   endfunction

   task automatic idle(input int n);
      repeat (n) @(posedge sys_clk_in);
   endtask

   task automatic flag_is(input logic exp);
      chk("flag", {31'h0, exp}, {31'h0, cmp_b_irq_flag_out});
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      idle(5);
      reset_n_in <= 1'b1;
      rdc(`ACEV_ADDR_REFCLK, 32'h00000000, 1'b0);
      rdc(`ACEV_ADDR_BCTRL, 32'h000000C0, 1'b0);
      rdc(12'h100, 32'h00000000, 1'b1);
      wr(12'h100, 32'h000000FF);
      wr(`ACEV_ADDR_REFCLK, 32'hFFFFFFE4);
      rdc(`ACEV_ADDR_REFCLK, 32'h000000E4, 1'b0);
      chk("b neg", 32'h2, {30'h0, b_neg});
      chk("a neg", 32'h0, {30'h0, a_neg});
      wr(`ACEV_ADDR_REFCLK, 32'h00000013);
      cmp_a_raw_in <= 1'b1;
      idle(4);
      chk("a out", 32'h1, {31'h0, cmp_a_out});
      cmp_a_raw_in <= 1'b0;
      chk("a neg", 32'h3, {30'h0, a_neg});
      chk("b neg", 32'h1, {30'h0, b_neg});
      wr(`ACEV_ADDR_BCTRL, 32'h00000089);
      chk("pos sel", 32'h2, {30'h0, b_pos});
      chk("connect", 32'h0, {31'h0, cmp_b_input_connect_out});
      chk("input only", 32'h1, {31'h0, pins_input_only_out});
      wr(`ACEV_ADDR_BCTRL, 32'h000000A1);
      chk("connect", 32'h1, {31'h0, cmp_b_input_connect_out});
      chk("input only", 32'h0, {31'h0, pins_input_only_out});
      $display("register test done");
      for (int m = 0; m < 8; m++) begin
         cmp_b_raw_in <= 1'b0;
         wr(`ACEV_ADDR_BCTRL, bv(1'b1, m[2:0]));
         idle(40);
         wr(`ACEV_ADDR_BCTRL, bv(1'b1, m[2:0]));
         idle(40);
         flag_is(m == 0);
         cmp_b_raw_in <= 1'b1;
         idle(40);
         flag_is(rise_set[m] | (m == 0));
         chk("b out", 32'h1, {31'h0, cmp_b_out});
         wr(`ACEV_ADDR_BCTRL, bv(1'b1, m[2:0]));
         idle(40);
         flag_is(m == 7);
         cmp_b_raw_in <= 1'b0;
         idle(40);
         flag_is(fall_set[m] | (m == 7));
      end
      $display("mode test done");
      wr(`ACEV_ADDR_BCTRL, bv(1'b1, ACEV_DEB_RISE));
      tmr_run <= 1'b0;
      idle(40);
      cmp_b_raw_in <= 1'b1;
      idle(40);
      flag_is(1'b0);
      tmr_run <= 1'b1;
      idle(40);
      flag_is(1'b1);
      cmp_b_raw_in <= 1'b0;
      idle(40);
      wr(`ACEV_ADDR_BCTRL, bv(1'b1, ACEV_DEB_RISE));
      cmp_b_raw_in <= 1'b1;
      idle(2);
      cmp_b_raw_in <= 1'b0;
      idle(40);
      flag_is(1'b0);
      $display("debounce test done");
      wr(`ACEV_ADDR_BCTRL, bv(1'b0, ACEV_RISE));
      cmp_b_raw_in <= 1'b1;
      idle(40);
      flag_is(1'b0);
      chk("b out", 32'h0, {31'h0, cmp_b_out});
      chk("input only", 32'h0, {31'h0, pins_input_only_out});
      cmp_b_raw_in <= 1'b0;
      $display("disable test done");
      wr(`ACEV_ADDR_BCTRL, bv(1'b1, ACEV_RISE));
      idle(40);
      wr(`ACEV_ADDR_CLR, 32'h00000003);
      wr(`ACEV_ADDR_IEN, 32'h00000001);
      chk("irq", 32'h0, {31'h0, irq_out});
      cmp_b_raw_in <= 1'b1;
      idle(40);
      chk("irq", 32'h1, {31'h0, irq_out});
      wr(`ACEV_ADDR_STAT, 32'h00000000);
      chk("irq", 32'h1, {31'h0, irq_out});
      wr(`ACEV_ADDR_IEN, 32'h00000000);
      chk("irq", 32'h0, {31'h0, irq_out});
      wr(`ACEV_ADDR_IEN, 32'h00000001);
      chk("irq", 32'h1, {31'h0, irq_out});
      wr(`ACEV_ADDR_CLR, 32'h00000003);
      rdc(`ACEV_ADDR_STAT, 32'h00000000, 1'b0);
      chk("irq", 32'h0, {31'h0, irq_out});
      $display("interrupt test done");
      test_done();
   end
endmodule
